// ---- hw/timer8_pair.v ----
// Purpose: Two 8-bit timer/event counters behind a byte-wide memory bus
// Assumes: One-cycle write strobe; reads combinationally addressed, registered out
// Notes:   Event pins are asynchronous and pass three flops before use
`timescale 1ns/1ps
`default_nettype none
`include "timer8_regs.vh"

module timer8_pair (
   input  wire        i_clk,          // 250 MHz main clock
   input  wire        i_rst_b,        // Async reset, low
   input  wire [15:0] i_addr,         // Byte address
   input  wire        i_wr,           // Write strobe
   input  wire        i_rd,           // Read strobe
   input  wire [7:0]  i_wdata,        // Write data
   output reg  [7:0]  o_rdata,        // Read data, valid cycle after i_rd
   input  wire        i_event_pin_a,  // Event input pin, timer A
   input  wire        i_event_pin_b,  // Event input pin, timer B
   output reg         o_timer_pin_a,  // Timer output pin A
   output reg         o_timer_pin_b,  // Timer output pin B
   output reg         o_match_irq_a,  // Match interrupt pulse A
   output reg         o_match_irq_b   // Match interrupt pulse B
);
   wire [`PRESCALE_WIDTH-1:0] tick;
   reg  [2:0] sync_a_q;
   reg  [2:0] sync_b_q;
   reg        lvl_a_q;
   reg        lvl_b_q;
   reg        rise_a;
   reg        fall_a;
   reg        rise_b;
   reg        fall_b;
   wire [7:0] mc_a;
   wire [7:0] cs_a;
   wire [7:0] cnt_a;
   wire [7:0] cmp_a;
   wire [7:0] mc_b;
   wire [7:0] cs_b;
   wire [7:0] cnt_b;
   wire [7:0] cmp_b;
   wire       irq_a;
   wire       irq_b;
   wire       pin_a;
   wire       pin_b;
   reg  [7:0] rdata_d;

   function hit;
      input [15:0] addr;
      input [15:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Event pin synchronisers
   // ----------------------------------------------------------------------
   // Edge seen once stages two and three agree on the new level
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_a_q <= 3'h0;
         sync_b_q <= 3'h0;
         lvl_a_q  <= 1'b0;
         lvl_b_q  <= 1'b0;
      end else begin
         sync_a_q <= {sync_a_q[1:0], i_event_pin_a};
         sync_b_q <= {sync_b_q[1:0], i_event_pin_b};
         if (sync_a_q[1] == sync_a_q[2]) begin
            lvl_a_q <= sync_a_q[2];
         end
         if (sync_b_q[1] == sync_b_q[2]) begin
            lvl_b_q <= sync_b_q[2];
         end
      end
   end

   always @* begin
      rise_a = (sync_a_q[1] == sync_a_q[2]) &&  sync_a_q[2] && !lvl_a_q;
      fall_a = (sync_a_q[1] == sync_a_q[2]) && !sync_a_q[2] &&  lvl_a_q;
      rise_b = (sync_b_q[1] == sync_b_q[2]) &&  sync_b_q[2] && !lvl_b_q;
      fall_b = (sync_b_q[1] == sync_b_q[2]) && !sync_b_q[2] &&  lvl_b_q;
   end

   prescaler u_prescaler (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .o_tick  (tick)
   );

   // ----------------------------------------------------------------------
   // Timer instances
   // ----------------------------------------------------------------------
   timer8_channel #(
      .TAP_MID  (`TAP_DIV4),
      .TAP_LONG (`TAP_DIV8192)
   ) u_timer_a (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_tick      (tick),
      .i_evt_rise  (rise_a),
      .i_evt_fall  (fall_a),
      .i_wr_mc     (i_wr && hit(i_addr, `ADDR_MODE_CONTROL_A)),
      .i_wr_cs     (i_wr && hit(i_addr, `ADDR_CLOCK_SELECT_A)),
      .i_wr_cmp    (i_wr && hit(i_addr, `ADDR_COMPARE_VALUE_A)),
      .i_wdata     (i_wdata),
      .o_mc        (mc_a),
      .o_cs        (cs_a),
      .o_count     (cnt_a),
      .o_cmp       (cmp_a),
      .o_match_irq (irq_a),
      .o_pin       (pin_a)
   );

   timer8_channel #(
      .TAP_MID  (`TAP_DIV16),
      .TAP_LONG (`TAP_DIV4096)
   ) u_timer_b (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_tick      (tick),
      .i_evt_rise  (rise_b),
      .i_evt_fall  (fall_b),
      .i_wr_mc     (i_wr && hit(i_addr, `ADDR_MODE_CONTROL_B)),
      .i_wr_cs     (i_wr && hit(i_addr, `ADDR_CLOCK_SELECT_B)),
      .i_wr_cmp    (i_wr && hit(i_addr, `ADDR_COMPARE_VALUE_B)),
      .i_wdata     (i_wdata),
      .o_mc        (mc_b),
      .o_cs        (cs_b),
      .o_count     (cnt_b),
      .o_cmp       (cmp_b),
      .o_match_irq (irq_b),
      .o_pin       (pin_b)
   );

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   always @* begin
      rdata_d = `RST_BYTE;
      if      (hit(i_addr, `ADDR_MODE_CONTROL_A))  rdata_d = mc_a;
      else if (hit(i_addr, `ADDR_CLOCK_SELECT_A))  rdata_d = cs_a;
      else if (hit(i_addr, `ADDR_COUNT_VALUE_A))   rdata_d = cnt_a;
      else if (hit(i_addr, `ADDR_COMPARE_VALUE_A)) rdata_d = cmp_a;
      else if (hit(i_addr, `ADDR_MODE_CONTROL_B))  rdata_d = mc_b;
      else if (hit(i_addr, `ADDR_CLOCK_SELECT_B))  rdata_d = cs_b;
      else if (hit(i_addr, `ADDR_COUNT_VALUE_B))   rdata_d = cnt_b;
      else if (hit(i_addr, `ADDR_COMPARE_VALUE_B)) rdata_d = cmp_b;
   end

   // Outputs registered; pins lag the channel by one cycle
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata       <= `RST_BYTE;
         o_timer_pin_a <= 1'b0;
         o_timer_pin_b <= 1'b0;
         o_match_irq_a <= 1'b0;
         o_match_irq_b <= 1'b0;
      end else begin
         if (i_rd) begin
            o_rdata <= rdata_d;
         end
         o_timer_pin_a <= pin_a;
         o_timer_pin_b <= pin_b;
         o_match_irq_a <= irq_a;
         o_match_irq_b <= irq_b;
      end
   end
endmodule // timer8_pair
`default_nettype wire

// ---- pkg/timer8_regs.vh ----
// Purpose: Register offsets, field positions, reset values and counts for the 8-bit timers
// Assumes: Byte-wide internal memory bus, one register per address
// Notes:   Definitions only
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_MODE_CONTROL_B   16'hff43
`define ADDR_CLOCK_SELECT_A   16'hff6a
`define ADDR_MODE_CONTROL_A   16'hff6b
`define ADDR_CLOCK_SELECT_B   16'hff8c
`define ADDR_COUNT_VALUE_A    16'hff50
`define ADDR_COMPARE_VALUE_A  16'hff51
`define ADDR_COUNT_VALUE_B    16'hff52
`define ADDR_COMPARE_VALUE_B  16'hff53

// ----------------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------------
`define MC_COUNT_ENABLE       7
`define MC_PWM_MODE           6
`define MC_FF_SET             3
`define MC_FF_RESET           2
`define MC_INVERT_POL         1
`define MC_OUTPUT_ENABLE      0
`define MC_READ_MASK          8'hc3

// ----------------------------------------------------------------------
// Reset values and clock select codes
// ----------------------------------------------------------------------
`define RST_BYTE              8'h00
`define CS_WIDTH              3
`define CS_EVT_FALL           3'h0
`define CS_EVT_RISE           3'h1
`define CS_DIV1               3'h2
`define CS_DIV2               3'h3
`define CS_DIV_MID            3'h4
`define CS_DIV64              3'h5
`define CS_DIV256             3'h6
`define CS_DIV_LONG           3'h7

// ----------------------------------------------------------------------
// Divider tap positions (main_clock / 2^(tap+1))
// ----------------------------------------------------------------------
`define PRESCALE_WIDTH        13
`define TAP_DIV2              0
`define TAP_DIV4              1
`define TAP_DIV16             3
`define TAP_DIV64             5
`define TAP_DIV256            7
`define TAP_DIV4096           11
`define TAP_DIV8192           12

`endif

// ---- hw/prescaler.v ----
// Purpose: Shared free-running divider giving one-cycle enable pulses
// Assumes: Single clock i_clk
// Notes:   o_tick[k] pulses once every 2^(k+1) cycles
`timescale 1ns/1ps
`default_nettype none
`include "timer8_regs.vh"

module prescaler (
   input  wire                        i_clk,    // Main clock
   input  wire                        i_rst_b,  // Async reset, low
   output reg  [`PRESCALE_WIDTH-1:0]  o_tick    // Divided enables
);
   reg [`PRESCALE_WIDTH-1:0] cnt_q;
   wire [`PRESCALE_WIDTH-1:0] cnt_d = cnt_q + {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1};
   genvar k;

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= {`PRESCALE_WIDTH{1'b0}};
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------------------------------------
   // Tick when all lower bits roll over
   // ----------------------------------------------------------------------
   generate
      for (k = 0; k < `PRESCALE_WIDTH; k = k + 1) begin : g_tick
         always @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               o_tick[k] <= 1'b0;
            end else begin
               o_tick[k] <= &cnt_d[k:0];
            end
         end
      end
   endgenerate
endmodule // prescaler
`default_nettype wire

// ---- hw/timer8_channel.v ----
// Purpose: One 8-bit timer/event counter with compare, output flip-flop and PWM
// Assumes: Register writes arrive as one-cycle strobes; event pin already synchronised
// Notes:   Divider ratio of the middle and longest codes set per instance
`timescale 1ns/1ps
`default_nettype none
`include "timer8_regs.vh"

module timer8_channel #(
   parameter integer TAP_MID  = `TAP_DIV4,
   parameter integer TAP_LONG = `TAP_DIV8192
) (
   input  wire                        i_clk,        // Main clock
   input  wire                        i_rst_b,      // Async reset, low
   input  wire [`PRESCALE_WIDTH-1:0]  i_tick,       // Divider enables
   input  wire                        i_evt_rise,   // Event pin rising edge
   input  wire                        i_evt_fall,   // Event pin falling edge
   input  wire                        i_wr_mc,      // Mode control write
   input  wire                        i_wr_cs,      // Clock select write
   input  wire                        i_wr_cmp,     // Compare write
   input  wire [7:0]                  i_wdata,      // Write data
   output reg  [7:0]                  o_mc,         // Mode control readback
   output reg  [7:0]                  o_cs,         // Clock select readback
   output reg  [7:0]                  o_count,      // Counter
   output reg  [7:0]                  o_cmp,        // Compare value
   output reg                         o_match_irq,  // Match pulse
   output reg                         o_pin         // Timer output pin
);
   reg  ce_q;
   reg  pwm_q;
   reg  inv_q;
   reg  oe_q;
   reg  ff_q;
   reg  pwm_ff_q;
   reg  tick;
   wire equal = (o_count == o_cmp);
   reg  ff_d;
   reg  pin_d;

   // ----------------------------------------------------------------------
   // Count source select
   // ----------------------------------------------------------------------
   always @* begin
      case (o_cs[`CS_WIDTH-1:0])
         `CS_EVT_FALL: tick = i_evt_fall;
         `CS_EVT_RISE: tick = i_evt_rise;
         `CS_DIV1:     tick = 1'b1;
         `CS_DIV2:     tick = i_tick[`TAP_DIV2];
         `CS_DIV_MID:  tick = i_tick[TAP_MID];
         `CS_DIV64:    tick = i_tick[`TAP_DIV64];
         `CS_DIV256:   tick = i_tick[`TAP_DIV256];
         default:      tick = i_tick[TAP_LONG];
      endcase
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cs  <= `RST_BYTE;
         o_cmp <= `RST_BYTE;
         ce_q  <= 1'b0;
         pwm_q <= 1'b0;
         inv_q <= 1'b0;
         oe_q  <= 1'b0;
      end else begin
         if (i_wr_cs) begin
            o_cs <= {5'b0_0000, i_wdata[`CS_WIDTH-1:0]};
         end
         if (i_wr_cmp) begin
            o_cmp <= i_wdata;
         end
         if (i_wr_mc) begin
            ce_q  <= i_wdata[`MC_COUNT_ENABLE];
            pwm_q <= i_wdata[`MC_PWM_MODE];
            inv_q <= i_wdata[`MC_INVERT_POL];
            oe_q  <= i_wdata[`MC_OUTPUT_ENABLE];
         end
      end
   end

   // Set/reset bits are write-only strobes, so they read back as zero
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_mc <= `RST_BYTE;
      end else begin
         o_mc <= {ce_q, pwm_q, 4'h0, inv_q, oe_q} & `MC_READ_MASK;
      end
   end

   // ----------------------------------------------------------------------
   // Counter and match
   // ----------------------------------------------------------------------
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_count     <= `RST_BYTE;
         o_match_irq <= 1'b0;
      end else begin
         o_match_irq <= 1'b0;
         if (!ce_q) begin
            o_count <= `RST_BYTE;
         end else if (tick) begin
            if (!pwm_q && equal) begin
               o_count     <= `RST_BYTE;
               o_match_irq <= 1'b1;
            end else begin
               o_count <= o_count + 8'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Output flip-flops
   // ----------------------------------------------------------------------
   // Forced levels act immediately, even while stopped
   always @* begin
      ff_d = ff_q;
      if (i_wr_mc && !i_wdata[`MC_PWM_MODE] &&
          (i_wdata[`MC_FF_SET] ^ i_wdata[`MC_FF_RESET])) begin
         ff_d = i_wdata[`MC_FF_SET];
      end else if (ce_q && tick && !pwm_q && equal && inv_q) begin
         ff_d = ~ff_q;
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ff_q     <= 1'b0;
         pwm_ff_q <= 1'b0;
      end else begin
         ff_q <= ff_d;
         if (!ce_q || !pwm_q) begin
            pwm_ff_q <= 1'b0;
         end else if (tick && o_count == 8'hff) begin
            pwm_ff_q <= 1'b1;
         end else if (tick && equal) begin
            pwm_ff_q <= 1'b0;
         end
      end
   end

   always @* begin
      if (!oe_q) begin
         pin_d = 1'b0;
      end else if (pwm_q) begin
         pin_d = pwm_ff_q ^ inv_q;
      end else begin
         pin_d = ff_q;
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pin <= 1'b0;
      end else begin
         o_pin <= pin_d;
      end
   end
endmodule // timer8_channel
`default_nettype wire

// ---- tb/timer8_pair_asserts.sv ----
// Purpose: Port-level checks on timer channel A of the pair
// Assumes: One-cycle write strobes; pin settles within three cycles of a write
// Notes:   Keeps its own image of mode control A, since readback lags
`timescale 1ns/1ps
`default_nettype none
`include "timer8_regs.vh"
module timer8_pair_asserts (
   input  wire logic        i_clk,          // Main clock
   input  wire logic        i_rst_b,        // Async reset, low
   input  wire logic [15:0] i_addr,         // Byte address
   input  wire logic        i_wr,           // Write strobe
   input  wire logic        i_rd,           // Read strobe
   input  wire logic [7:0]  i_wdata,        // Write data
   input  wire logic [7:0]  o_rdata,        // Read data
   input  wire logic        o_timer_pin_a,  // Timer output pin A
   input  wire logic        o_match_irq_a   // Match pulse A
);
   logic [7:0] mc_q;
   wire        mc_wr  = i_wr && (i_addr == `ADDR_MODE_CONTROL_A);
   wire        cnt_rd = i_rd && (i_addr == `ADDR_COUNT_VALUE_A);

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) mc_q <= 8'h00;
      else if (mc_wr) mc_q <= i_wdata;
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   // -------------------------------------------------------------------
   // Sequences
   // -------------------------------------------------------------------
   sequence s_cmp_wr;
      i_wr && (i_addr == `ADDR_COMPARE_VALUE_A);
   endsequence
   sequence s_cmp_rd;
      i_rd && !i_wr && (i_addr == `ADDR_COMPARE_VALUE_A);
   endsequence
   // Stopped, clear mode, no inversion, output on, one flop action
   sequence s_ff_write(logic [1:0] sr);
      mc_wr && (i_wdata[7:6] == 2'h0) && (i_wdata[1:0] == 2'h1) && (i_wdata[3:2] == sr);
   endsequence

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   a_rdata_holds: assert property (
      !$past(i_rd) |-> $stable(o_rdata)) else $error("read data moved without a read");
   a_cs_upper_zero: assert property (
      i_rd && (i_addr == `ADDR_CLOCK_SELECT_A) |=> o_rdata[7:3] == 5'h00)
      else $error("clock select upper bits not zero");
   a_mc_fixed_zero: assert property (
      i_rd && (i_addr == `ADDR_MODE_CONTROL_A) |=> o_rdata[5:2] == 4'h0)
      else $error("mode control fixed bits not zero");
   a_cmp_readback: assert property (
      s_cmp_wr ##1 s_cmp_rd |=> o_rdata == $past(i_wdata, 2)) else $error("compare readback");
   a_ff_set_pin: assert property (
      s_ff_write(2'h2) |-> ##3 o_timer_pin_a) else $error("flop set not on pin");
   a_ff_reset_pin: assert property (
      s_ff_write(2'h1) |-> ##3 !o_timer_pin_a) else $error("flop reset not on pin");
   a_oe_low_pin: assert property (
      (!mc_q[0] && $stable(mc_q))[*4] |-> !o_timer_pin_a) else $error("pin high while disabled");
   a_pwm_stop_idle: assert property (
      (mc_q[6] && !mc_q[7] && mc_q[0] && $stable(mc_q))[*4] |-> o_timer_pin_a == mc_q[1])
      else $error("stopped pwm output not inactive");
   a_stop_count_zero: assert property (
      (!mc_q[7])[*4] ##0 cnt_rd |=> o_rdata == 8'h00) else $error("stopped count not zero");
   a_stop_no_irq: assert property (
      (!mc_q[7])[*6] |-> !o_match_irq_a) else $error("match pulse while stopped");
endmodule // timer8_pair_asserts
`default_nettype wire

// ---- tb/pin_partner.sv ----
// Purpose: Far side of the timer pins: event source and output watcher
// Assumes: Each event level held four cycles, above the synchroniser minimum
// Notes:   Event pins idle low between pulses
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   input  wire logic        i_clk,          // Main clock
   input  wire logic        i_timer_pin_a,  // Timer output pin A
   output var  logic        o_event_pin_a,  // Event pin A
   output var  logic        o_event_pin_b,  // Event pin B
   output var  logic [15:0] o_toggles_a     // Edges seen on pin A
);
   initial begin
      o_event_pin_a = 1'b0;
      o_event_pin_b = 1'b0;
      o_toggles_a = 16'h0000;
   end
   // Counts both edges; only differences mean anything
   always @(posedge i_timer_pin_a or negedge i_timer_pin_a) begin
      o_toggles_a <= o_toggles_a + 16'h0001;
   end
   // One full pulse on pin B, or on pin A when sel is low
   task automatic pulse(input logic sel);
      repeat (2) begin
         @(posedge i_clk);
         #1;
         if (sel) o_event_pin_b = ~o_event_pin_b;
         else o_event_pin_a = ~o_event_pin_a;
         repeat (3) @(posedge i_clk);
      end
   endtask
endmodule // pin_partner
`default_nettype wire

// ---- tb/timer8_pair_bench.sv ----
// Purpose: Self-checking bench for the two-channel 8-bit timer
// Assumes: Pin settles within three cycles of a mode write
// Notes:   Count-clock rate measured as match spacing with compare zero
`timescale 1ns/1ps
`default_nettype none
`include "timer8_regs.vh"
module timer8_pair_bench;
   logic        i_clk;
   logic        i_rst_b;
   logic        i_wr;
   logic        i_rd;
   logic [15:0] i_addr;
   logic [7:0]  i_wdata;
   logic [7:0]  o_rdata;
   logic        evt_a;
   logic        evt_b;
   logic        pin_a;
   logic        pin_b;
   logic        irq_a;
   logic        irq_b;
   logic [15:0] tog_a;
   int          n_mismatch;
   int          total_checks;
   int          n_irq_a;
   int          n_irq_b;
   int          n;
   int          k;
   int          t0;
   logic        ch;
   logic [15:0] adr[9] = '{`ADDR_MODE_CONTROL_A, `ADDR_CLOCK_SELECT_A, `ADDR_COUNT_VALUE_A,
      `ADDR_COMPARE_VALUE_A, `ADDR_MODE_CONTROL_B, `ADDR_CLOCK_SELECT_B, `ADDR_COUNT_VALUE_B,
      `ADDR_COMPARE_VALUE_B, 16'hff00};
   logic [7:0]  mcv[6] = '{8'h08, 8'h00, 8'h01, 8'h05, 8'h31, 8'h09};
   logic [5:0]  pnx = 6'h24;
   logic [7:0]  cv[3] = '{8'h00, 8'h03, 8'hff};
   int          div[12] = '{1, 2, 4, 64, 256, 8192, 1, 2, 16, 64, 256, 4096};

   timer8_pair i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr),
      .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_event_pin_a(evt_a),
      .i_event_pin_b(evt_b), .o_timer_pin_a(pin_a), .o_timer_pin_b(pin_b),
      .o_match_irq_a(irq_a), .o_match_irq_b(irq_b));
   pin_partner i_pins (.i_clk(i_clk), .i_timer_pin_a(pin_a), .o_event_pin_a(evt_a),
      .o_event_pin_b(evt_b), .o_toggles_a(tog_a));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // Sampled mid-cycle to stay clear of the launching edge
   always @(negedge i_clk) begin
      n_irq_a += (irq_a === 1'b1);
      n_irq_b += (irq_b === 1'b1);
   end

   // -------------------------------------------------------------------
   // Access and compare tasks
   // -------------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         n_mismatch++;
         $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_addr = a;
      i_wdata = d;
      i_rd = 1'b0;
      i_wr = 1'b1;
      @(posedge i_clk);
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      i_addr = a;
      i_wr = 1'b0;
      i_rd = 1'b1;
      @(posedge i_clk);
      #1;
      chk(o_rdata, exp);
   endtask
   task automatic cyc(input int c);
      i_wr = 1'b0;
      i_rd = 1'b0;
      repeat (c) @(posedge i_clk);
      #1;
   endtask
   task automatic gap(input logic b, output int g);
      g = 0;
      k = 0;
      cyc(1);
      while (((b ? irq_b : irq_a) !== 1'b1) && k < 20000) begin
         cyc(1);
         k++;
      end
      do begin
         cyc(1);
         g++;
      end while (((b ? irq_b : irq_a) !== 1'b1) && g < 20000);
   endtask
   task automatic level_count(input logic lv, output int c);
      c = 0;
      repeat (256) begin
         cyc(1);
         c += (pin_a === lv);
      end
   endtask
   task automatic close_out;
      $display("mismatches %0d, checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #350000;
      n_mismatch++;
      close_out;
   end

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      i_rst_b = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 16'h0000;
      i_wdata = 8'h00;
      n_mismatch = 0;
      total_checks = 0;
      n_irq_a = 0;
      n_irq_b = 0;
      repeat (2) @(posedge i_clk);
      #1;
      i_rst_b = 1'b1;
      foreach (adr[j]) rd(adr[j], 8'h00);
      wr(`ADDR_COMPARE_VALUE_A, 8'ha5);
      rd(`ADDR_COMPARE_VALUE_A, 8'ha5);
      wr(`ADDR_COMPARE_VALUE_B, 8'hff);
      rd(`ADDR_COMPARE_VALUE_B, 8'hff);
      wr(`ADDR_COUNT_VALUE_A, 8'h5a);
      rd(`ADDR_COUNT_VALUE_A, 8'h00);
      wr(`ADDR_CLOCK_SELECT_B, 8'h06);
      rd(`ADDR_CLOCK_SELECT_B, 8'h06);
      wr(16'hff00, 8'h5a);
      rd(16'hff00, 8'h00);
      foreach (mcv[j]) begin
         wr(`ADDR_MODE_CONTROL_A, mcv[j]);
         cyc(3);
         chk({7'h00, pin_a}, {7'h00, pnx[j]});
      end
      rd(`ADDR_MODE_CONTROL_A, 8'h01);
      wr(`ADDR_CLOCK_SELECT_A, 8'h02);
      wr(`ADDR_MODE_CONTROL_A, 8'h03);
      foreach (cv[j]) begin
         wr(`ADDR_COMPARE_VALUE_A, cv[j]);
         wr(`ADDR_MODE_CONTROL_A, 8'h83);
         gap(1'b0, n);
         chk_n(n, int'(cv[j]) + 1);
         wr(`ADDR_MODE_CONTROL_A, 8'h03);
      end
      wr(`ADDR_COMPARE_VALUE_A, 8'h03);
      wr(`ADDR_MODE_CONTROL_A, 8'h83);
      cyc(8);
      t0 = int'(tog_a);
      k = n_irq_a;
      cyc(40);
      chk_n(int'(tog_a) - t0, 10);
      chk_n(n_irq_a - k, 10);
      wr(`ADDR_MODE_CONTROL_A, 8'h03);
      cyc(4);
      rd(`ADDR_COUNT_VALUE_A, 8'h00);
      foreach (div[j]) begin
         ch = (j >= 6);
         wr(ch ? `ADDR_CLOCK_SELECT_B : `ADDR_CLOCK_SELECT_A, 8'(j % 6 + 2));
         wr(ch ? `ADDR_COMPARE_VALUE_B : `ADDR_COMPARE_VALUE_A, 8'h00);
         wr(ch ? `ADDR_MODE_CONTROL_B : `ADDR_MODE_CONTROL_A, ch ? 8'h80 : 8'h83);
         gap(ch, n);
         chk_n(n, div[j]);
         wr(ch ? `ADDR_MODE_CONTROL_B : `ADDR_MODE_CONTROL_A, ch ? 8'h00 : 8'h03);
      end
      wr(`ADDR_CLOCK_SELECT_B, 8'h01);
      wr(`ADDR_COMPARE_VALUE_B, 8'h01);
      wr(`ADDR_MODE_CONTROL_B, 8'h80);
      cyc(1);
      k = n_irq_b;
      i_pins.pulse(1'b1);
      i_pins.pulse(1'b1);
      cyc(8);
      chk_n(n_irq_b - k, 1);
      rd(`ADDR_COUNT_VALUE_B, 8'h00);
      wr(`ADDR_MODE_CONTROL_B, 8'h00);
      wr(`ADDR_CLOCK_SELECT_B, 8'h00);
      wr(`ADDR_MODE_CONTROL_B, 8'h80);
      cyc(1);
      i_pins.pulse(1'b1);
      cyc(8);
      rd(`ADDR_COUNT_VALUE_B, 8'h01);
      wr(`ADDR_CLOCK_SELECT_A, 8'h02);
      wr(`ADDR_COMPARE_VALUE_A, 8'h40);
      wr(`ADDR_MODE_CONTROL_A, 8'h43);
      wr(`ADDR_MODE_CONTROL_A, 8'hc3);
      cyc(300);
      level_count(1'b0, n);
      chk_n(n, 65);
      wr(`ADDR_MODE_CONTROL_A, 8'hc1);
      cyc(8);
      level_count(1'b1, n);
      chk_n(n, 65);
      wr(`ADDR_MODE_CONTROL_A, 8'hc3);
      cyc(8);
      wr(`ADDR_MODE_CONTROL_A, 8'h43);
      cyc(4);
      chk({7'h00, pin_a}, 8'h01);
      wr(`ADDR_MODE_CONTROL_A, 8'h42);
      cyc(4);
      chk({7'h00, pin_a}, 8'h00);
      // Falling-edge event count on channel A
      wr(`ADDR_MODE_CONTROL_A, 8'h02);
      wr(`ADDR_CLOCK_SELECT_A, 8'h00);
      wr(`ADDR_COMPARE_VALUE_A, 8'h05);
      wr(`ADDR_MODE_CONTROL_A, 8'h82);
      cyc(1);
      i_pins.pulse(1'b0);
      cyc(8);
      rd(`ADDR_COUNT_VALUE_A, 8'h01);
      // Forced level on timer pin B
      wr(`ADDR_MODE_CONTROL_B, 8'h00);
      wr(`ADDR_MODE_CONTROL_B, 8'h01);
      wr(`ADDR_MODE_CONTROL_B, 8'h09);
      cyc(3);
      chk({7'h00, pin_b}, 8'h01);
      close_out;
   end
endmodule // timer8_pair_bench

bind timer8_pair timer8_pair_asserts u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .o_timer_pin_a(o_timer_pin_a), .o_match_irq_a(o_match_irq_a));
`default_nettype wire
